// file: common/link_cfg_if.sv
// Configuration channel between the transmit end and the far receiver.
// Both ends share one clock; the bench joins the two modports.
interface link_cfg_if;
    import link_cfg_pkg::*;
    logic cfgValid;
    logic cfgReady;
    link_cfg_t cfgWord;
    modport tx (output cfgValid, output cfgWord, input cfgReady);
    modport rx (input cfgValid, input cfgWord, output cfgReady);
endinterface

// file: common/link_cfg_pkg.sv
// Shared constants, types and legality checks for the 16-bit-word link setup.
// Assumes both ends run on one clock; rates are held in kbit/s and kHz.
package link_cfg_pkg;

    // ----------------------------------------------------------------
    // Register map of the transmit end
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] REG_SHAPE = 8'h00;
    localparam logic [7:0] REG_WORD = 8'h04;
    localparam logic [7:0] REG_DECIM = 8'h08;
    localparam logic [7:0] REG_RATE = 8'h0C;
    localparam logic [7:0] REG_CLOCK = 8'h10;
    localparam logic [7:0] REG_CMD = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;

    // ----------------------------------------------------------------
    // Limits
    // ----------------------------------------------------------------
    localparam logic [23:0] RATE_MIN_KBPS = 24'h19_BFCC;
    localparam logic [23:0] BAND1_KBPS = 24'h33_7F98;
    localparam logic [23:0] BAND2_KBPS = 24'h66_FF30;
    localparam logic [23:0] BAND3_KBPS = 24'hCD_FE60;
    localparam logic [23:0] RATE_MAX_KBPS = 24'hF4_2400;
    localparam logic [7:0] BAND_SET_0 = 8'h50;
    localparam logic [7:0] BAND_SET_1 = 8'h10;
    localparam logic [7:0] BAND_SET_2 = 8'h00;
    localparam logic [7:0] BAND_SET_3 = 8'h30;
    localparam logic [39:0] DIVIDER_RATIO = 40'h00_0000_0028;
    localparam logic [39:0] LANE_MULT = 40'h00_0000_0014;
    localparam logic [9:0] LCM_MAX = 10'h040;
    localparam logic [9:0] OCT_PER_SAMPLE = 10'h002;
    localparam logic [5:0] K_MAX = 6'h20;
    localparam logic [5:0] KMIN_F1 = 6'h14;
    localparam logic [5:0] KMIN_F2 = 6'h0C;
    localparam logic [5:0] KMIN_F4 = 6'h08;
    localparam logic [5:0] KMIN_F8 = 6'h04;
    localparam logic [4:0] F_MAX = 5'h10;
    localparam logic [4:0] RES_MIN = 5'h08;
    localparam logic [4:0] RES_MAX = 5'h10;
    localparam logic [1:0] CS_MAX = 2'h3;
    localparam logic [7:0] MULT_5 = 8'h05;
    localparam logic [7:0] MULT_10 = 8'h0A;
    localparam logic [7:0] MULT_20 = 8'h14;
    localparam logic [7:0] MULT_40 = 8'h28;
    localparam logic [7:0] MULT_80 = 8'h50;
    localparam logic [7:0] MULT_160 = 8'hA0;

    // Decimation sets, bit d set when ratio d is allowed
    localparam logic [63:0] D_1 = 64'h0000_0000_0000_0002;
    localparam logic [63:0] D_123 = 64'h0000_0000_0000_000E;
    localparam logic [63:0] D_2456 = 64'h0000_0000_0000_0074;
    localparam logic [63:0] D_456 = 64'h0000_0000_0000_0070;
    localparam logic [63:0] D_2 = 64'h0000_0000_0000_0004;
    localparam logic [63:0] D_246 = 64'h0000_0000_0000_0054;
    localparam logic [63:0] D_4 = 64'h0000_0000_0000_0010;
    localparam logic [63:0] D_4812 = 64'h0000_0000_0000_1110;
    localparam logic [63:0] D_481012 = 64'h0000_0000_0000_1510;
    localparam logic [63:0] D_8162024 = 64'h0000_0000_0111_0100;
    localparam logic [63:0] D_164048 = 64'h0001_0100_0001_0000;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0] lanes;
        logic [3:0] convs;
        logic [4:0] octets;
        logic [2:0] samples;
        logic hiDens;
        logic [4:0] resol;
        logic [1:0] ctrlBits;
        logic [5:0] frames;
        logic [5:0] decim;
        logic [23:0] laneKbps;
        logic [20:0] sampleKhz;
    } link_cfg_t;

    typedef struct packed {
        logic rateRange;
        logic divider;
        logic lcm;
        logic frameCnt;
        logic shape;
        logic decim;
        logic rate;
    } cfg_err_t;

    typedef struct packed {
        logic [14:0] pad;
        logic hiDens;
        logic [2:0] samples;
        logic [4:0] octets;
        logic [3:0] convs;
        logic [3:0] lanes;
    } shape_reg_t;

    typedef struct packed {
        logic [18:0] pad;
        logic [5:0] frames;
        logic [1:0] ctrlBits;
        logic [4:0] resol;
    } word_reg_t;

    typedef struct packed {
        logic [28:0] pad;
        logic clrReject;
        logic dryRun;
        logic commit;
    } cmd_reg_t;

    typedef struct packed {
        logic [12:0] pad;
        logic bufFull;
        logic rejected;
        logic busy;
        logic [7:0] band;
        logic legal;
        cfg_err_t err;
    } status_reg_t;

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic [1:0] bandOf(input logic [23:0] kbps);
        if (kbps > BAND3_KBPS) return 2'h3;
        if (kbps >= BAND2_KBPS) return 2'h2;
        if (kbps >= BAND1_KBPS) return 2'h1;
        return 2'h0;
    endfunction

    function automatic logic [7:0] bandSetting(input logic [23:0] kbps);
        case (bandOf(kbps))
            2'h3: return BAND_SET_3;
            2'h2: return BAND_SET_2;
            2'h1: return BAND_SET_1;
            default: return BAND_SET_0;
        endcase
    endfunction

    function automatic logic [63:0] decimMask(input link_cfg_t c);
        logic [3:0][63:0] t;
        logic [39:0] mult;
        t = '0;
        mult = (c.lanes == 4'h0) ? '0 : LANE_MULT * 40'(c.convs) / 40'(c.lanes);
        case (mult[7:0])
            MULT_5: t[0] = D_1;
            MULT_10: t[1:0] = {D_1, D_123};
            MULT_20: t[2:0] = {D_1, D_123, (c.convs == 4'h2 && c.octets == 5'h02) ? D_456 : D_2456};
            MULT_40: t = (c.convs == 4'h8) ? {64'h0, D_2, D_246, D_481012}
                                            : {D_1, D_123, D_2456, D_481012};
            MULT_80: t = {D_2, D_246, D_481012, D_8162024};
            MULT_160: t = {D_4, D_4812, D_8162024, D_164048};
            default: t = '0;
        endcase
        return t[bandOf(c.laneKbps)];
    endfunction

    function automatic cfg_err_t checkCfg(input link_cfg_t c);
        cfg_err_t e;
        logic laneOk, convOk;
        logic [39:0] lhs, rhs;
        logic [9:0] fk, q, lcmv;
        logic [10:0] kf;
        logic [5:0] kMin;
        logic [63:0] allowed;
        e = '0;
        laneOk = c.lanes inside {4'h1, 4'h2, 4'h4};
        convOk = c.convs inside {4'h1, 4'h2, 4'h4, 4'h8};
        e.rateRange = c.laneKbps < RATE_MIN_KBPS || c.laneKbps > RATE_MAX_KBPS;
        e.divider = 40'(c.laneKbps) > 40'(c.sampleKhz) * DIVIDER_RATIO;
        e.shape = !laneOk || !convOk || c.resol < RES_MIN || c.resol > RES_MAX
            || c.ctrlBits > CS_MAX || c.octets > F_MAX
            || 10'(c.octets) * 10'(c.lanes) != OCT_PER_SAMPLE * 10'(c.convs) * 10'(c.samples)
            || !(c.samples inside {3'h1, 3'h2} || (c.convs == 4'h1 && c.lanes == 4'h4 && c.samples == 3'h4))
            || (c.octets == F_MAX && !(c.convs == 4'h8 && c.lanes == 4'h1))
            || c.hiDens != (c.octets == 5'h01);
        lhs = 40'(c.laneKbps) * 40'(c.lanes) * 40'(c.decim);
        rhs = LANE_MULT * 40'(c.convs) * 40'(c.sampleKhz);
        e.rate = lhs != rhs || c.decim == 6'h00;
        // M and L are powers of two; with L below M the clock ratio is a
        // fraction dividing the decimation, so the multiple is the decimation
        fk = 10'(c.decim) * 10'(c.lanes);
        q = convOk ? fk / 10'(c.convs) : '0;
        lcmv = (q > 10'(c.decim)) ? q : 10'(c.decim);
        e.lcm = !convOk || lcmv > LCM_MAX;
        case (c.octets)
            5'h01: kMin = KMIN_F1;
            5'h02: kMin = KMIN_F2;
            5'h04: kMin = KMIN_F4;
            default: kMin = KMIN_F8;
        endcase
        kf = 11'(c.frames) * 11'(c.octets);
        // Low two bits zero means divisible by four
        e.frameCnt = kf[1:0] != 2'h0 || c.frames[1:0] != 2'h0 || c.frames < kMin || c.frames > K_MAX;
        allowed = decimMask(c);
        e.decim = !allowed[c.decim];
        return e;
    endfunction

endpackage

// file: src/link_cfg_rx.sv
// Far receiver end: takes configuration words, rechecks and applies them.
// Assumes the transmit end on the link modport and the same clock.
module link_cfg_rx (
    input wire logic clk,
    input wire logic rst_n,
    link_cfg_if.rx link,
    input wire logic stall,
    output logic linkUp,
    output logic cfgFault,
    output logic loadPulse,
    output logic [7:0] bandSet,
    output link_cfg_pkg::link_cfg_t activeCfg
);
    import link_cfg_pkg::*;

    // ----------------------------------------------------------------
    // Take and apply
    // ----------------------------------------------------------------
    logic readyReg, readyNext;
    logic upReg, upNext;
    logic faultReg, faultNext;
    logic loadReg, loadNext;
    logic [7:0] bandReg, bandNext;
    link_cfg_t activeReg, activeNext;
    logic take;

    always_comb begin
        take = link.cfgValid && readyReg;
        readyNext = !stall;
        upNext = upReg;
        faultNext = faultReg;
        loadNext = 1'b0;
        bandNext = bandReg;
        activeNext = activeReg;
        if (take) begin
            if (checkCfg(link.cfgWord) == '0) begin
                activeNext = link.cfgWord;
                bandNext = bandSetting(link.cfgWord.laneKbps);
                upNext = 1'b1;
                faultNext = 1'b0;
                loadNext = 1'b1;
            end else begin
                // Keep last good setup but drop link
                upNext = 1'b0;
                faultNext = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readyReg <= 1'b0;
            upReg <= 1'b0;
            faultReg <= 1'b0;
            loadReg <= 1'b0;
            bandReg <= '0;
            activeReg <= '0;
        end else begin
            readyReg <= readyNext;
            upReg <= upNext;
            faultReg <= faultNext;
            loadReg <= loadNext;
            bandReg <= bandNext;
            activeReg <= activeNext;
        end
    end

    assign link.cfgReady = readyReg;
    assign linkUp = upReg;
    assign cfgFault = faultReg;
    assign loadPulse = loadReg;
    assign bandSet = bandReg;
    assign activeCfg = activeReg;

endmodule // link_cfg_rx

// file: src/link_cfg_tx.sv
// Transmit end: software-facing registers, legality check, two-entry buffer.
// Assumes a same-clock far receiver on the link modport and a plain reg port.
//
// Function
// - Lane rate within 1.6875 to 16 Gbps
// - Lane rate over forty below sample clock
// - LCM of clock ratio and decimation <=64
// - Band setting follows lane rate bands
// - Middle band 6750 to 13500 gives 0x00
// - Frames times octets divisible by four
// - Lane rate equals twenty M over L
// - Octets equal 2MS/L, listed sizes only
// - High density only on one-octet frames
// - Decimation must match table for band
// - Resolution 8 to 16, control bits 0-3
// - One, two or four lanes only
// - One, two, four or eight converters
module link_cfg_tx (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [link_cfg_pkg::ADDR_W-1:0] addr,
    input wire logic [link_cfg_pkg::DATA_W-1:0] wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    output logic [link_cfg_pkg::DATA_W-1:0] rdData,
    link_cfg_if.tx link
);
    import link_cfg_pkg::*;

    typedef enum logic {CM_IDLE, CM_EVAL} commit_st_t;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    shape_reg_t shapeReg, shapeNext;
    word_reg_t wordReg, wordNext;
    logic [5:0] decimReg, decimNext;
    logic [23:0] rateReg, rateNext;
    logic [20:0] clockReg, clockNext;
    logic [DATA_W-1:0] rdDataReg, rdDataNext;
    cmd_reg_t cmdIn;
    status_reg_t statusView;

    always_comb begin
        cmdIn = wrData;
        shapeNext = shapeReg;
        wordNext = wordReg;
        decimNext = decimReg;
        rateNext = rateReg;
        clockNext = clockReg;
        if (wrStb) begin
            case (addr)
                REG_SHAPE: begin
                    shapeNext = wrData;
                    shapeNext.pad = '0;
                end
                REG_WORD: begin
                    wordNext = wrData;
                    wordNext.pad = '0;
                end
                REG_DECIM: decimNext = wrData[5:0];
                REG_RATE: rateNext = wrData[23:0];
                REG_CLOCK: clockNext = wrData[20:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shapeReg <= '0;
            wordReg <= '0;
            decimReg <= '0;
            rateReg <= '0;
            clockReg <= '0;
        end else begin
            shapeReg <= shapeNext;
            wordReg <= wordNext;
            decimReg <= decimNext;
            rateReg <= rateNext;
            clockReg <= clockNext;
        end
    end

    // ----------------------------------------------------------------
    // Commit and check
    // ----------------------------------------------------------------
    // Snapshot at commit so later register writes cannot race the check
    commit_st_t stReg, stNext;
    link_cfg_t snapReg, snapNext;
    link_cfg_t cfgNow;
    cfg_err_t errNow, lastErrReg, lastErrNext;
    logic [7:0] bandReg, bandNext;
    logic dryReg, dryNext;
    logic rejectReg, rejectNext;
    logic push;
    logic spareValidReg;

    always_comb begin
        cfgNow = '{lanes: shapeReg.lanes, convs: shapeReg.convs,
                   octets: shapeReg.octets, samples: shapeReg.samples,
                   hiDens: shapeReg.hiDens, resol: wordReg.resol,
                   ctrlBits: wordReg.ctrlBits, frames: wordReg.frames,
                   decim: decimReg, laneKbps: rateReg, sampleKhz: clockReg};
        errNow = checkCfg(snapReg);
        stNext = stReg;
        snapNext = snapReg;
        lastErrNext = lastErrReg;
        bandNext = bandReg;
        dryNext = dryReg;
        rejectNext = rejectReg;
        push = 1'b0;
        if (wrStb && addr == REG_CMD && cmdIn.clrReject) begin
            rejectNext = 1'b0;
        end
        case (stReg)
            CM_IDLE: begin
                if (wrStb && addr == REG_CMD && cmdIn.commit) begin
                    snapNext = cfgNow;
                    dryNext = cmdIn.dryRun;
                    stNext = CM_EVAL;
                end
            end
            CM_EVAL: begin
                lastErrNext = errNow;
                bandNext = bandSetting(snapReg.laneKbps);
                stNext = CM_IDLE;
                if (!dryReg) begin
                    // Set after clear so a same-cycle reject is kept
                    if (errNow == '0 && !spareValidReg) begin
                        push = 1'b1;
                    end else begin
                        rejectNext = 1'b1;
                    end
                end
            end
            default: stNext = CM_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stReg <= CM_IDLE;
            snapReg <= '0;
            lastErrReg <= '0;
            bandReg <= '0;
            dryReg <= 1'b0;
            rejectReg <= 1'b0;
        end else begin
            stReg <= stNext;
            snapReg <= snapNext;
            lastErrReg <= lastErrNext;
            bandReg <= bandNext;
            dryReg <= dryNext;
            rejectReg <= rejectNext;
        end
    end

    // ----------------------------------------------------------------
    // Two-entry buffer toward the receiver
    // ----------------------------------------------------------------
    // Head drives the link straight from flops; spare absorbs one stall
    link_cfg_t headReg, headNext, spareReg, spareNext;
    logic headValidReg, headValidNext, spareValidNext;
    logic pop;

    always_comb begin
        pop = headValidReg && link.cfgReady;
        headNext = headReg;
        headValidNext = headValidReg;
        spareNext = spareReg;
        spareValidNext = spareValidReg;
        if (pop || !headValidReg) begin
            if (spareValidReg) begin
                headNext = spareReg;
                headValidNext = 1'b1;
                spareValidNext = 1'b0;
            end else begin
                headNext = snapReg;
                headValidNext = push;
            end
        end else if (push) begin
            spareNext = snapReg;
            spareValidNext = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            headReg <= '0;
            headValidReg <= 1'b0;
            spareReg <= '0;
            spareValidReg <= 1'b0;
        end else begin
            headReg <= headNext;
            headValidReg <= headValidNext;
            spareReg <= spareNext;
            spareValidReg <= spareValidNext;
        end
    end

    assign link.cfgValid = headValidReg;
    assign link.cfgWord = headReg;

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    always_comb begin
        statusView = '0;
        statusView.err = lastErrReg;
        statusView.legal = lastErrReg == '0;
        statusView.band = bandReg;
        statusView.busy = stReg != CM_IDLE || headValidReg;
        statusView.rejected = rejectReg;
        statusView.bufFull = spareValidReg;
        rdDataNext = '0;
        if (rdStb) begin
            case (addr)
                REG_SHAPE: rdDataNext = shapeReg;
                REG_WORD: rdDataNext = wordReg;
                REG_DECIM: rdDataNext = DATA_W'(decimReg);
                REG_RATE: rdDataNext = DATA_W'(rateReg);
                REG_CLOCK: rdDataNext = DATA_W'(clockReg);
                REG_STATUS: rdDataNext = statusView;
                default: rdDataNext = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdDataReg <= '0;
        end else begin
            rdDataReg <= rdDataNext;
        end
    end

    assign rdData = rdDataReg;

endmodule // link_cfg_tx

// file: tb/link_cfg_sva.sv
// Checker for the configuration link and the receiver's applied state.
// Assumes one clock; instantiated beside the interface, inputs by name.
module link_cfg_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cfgValid,
    input wire logic cfgReady,
    input wire link_cfg_pkg::link_cfg_t cfgWord,
    input wire logic loadPulse,
    input wire logic linkUp,
    input wire logic [7:0] bandSet,
    input wire link_cfg_pkg::link_cfg_t activeCfg
);
    timeunit 1ns;
    timeprecision 100ps;
    import link_cfg_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // Link handshake
    // ------------------------------------------------------------
    sequence sTake;
        cfgValid && cfgReady;
    endsequence
    sequence sWait;
        cfgValid && !cfgReady;
    endsequence
    a_hold_word: assert property (sWait |=> cfgValid && $stable(cfgWord))
        else $error("link word changed while waiting");
    a_take_load: assert property (sTake |=> loadPulse && linkUp)
        else $error("taken word not applied");
    a_take_copy: assert property (sTake |=> activeCfg == $past(cfgWord))
        else $error("applied config differs from sent word");
    a_no_load: assert property (!(cfgValid && cfgReady) |=> !loadPulse)
        else $error("load without a taken word");
    // ------------------------------------------------------------
    // Legality of every word offered, and band setting on each load
    // ------------------------------------------------------------
    a_rate_range: assert property (cfgValid |-> cfgWord.laneKbps >= 24'h19_BFCC
        && cfgWord.laneKbps <= 24'hF4_2400)
        else $error("lane rate out of range");
    a_clock_div: assert property (cfgValid |-> 40'(cfgWord.laneKbps)
        <= 40'(cfgWord.sampleKhz) * DIVIDER_RATIO)
        else $error("lane rate over forty above sample clock");
    a_frame_mult: assert property (cfgValid |-> (cfgWord.frames * cfgWord.octets) % 4 == 0
        && cfgWord.frames >= 4 && cfgWord.frames <= 32)
        else $error("frames per multiframe illegal");
    a_dens_oct: assert property (cfgValid |-> cfgWord.hiDens == (cfgWord.octets == 5'h01))
        else $error("high density flag mismatch");
    a_lane_cnt: assert property (cfgValid |-> cfgWord.lanes inside {4'h1, 4'h2, 4'h4}
        && cfgWord.convs inside {4'h1, 4'h2, 4'h4, 4'h8})
        else $error("lane or converter count illegal");
    a_band_map: assert property (loadPulse |-> bandSet ==
        (activeCfg.laneKbps > 24'hCD_FE60 ? 8'h30 : activeCfg.laneKbps >= 24'h66_FF30 ? 8'h00
        : activeCfg.laneKbps >= 24'h33_7F98 ? 8'h10 : 8'h50))
        else $error("band setting does not follow lane rate");
endmodule // link_cfg_sva

// file: tb/test_jesd204b_link_param_config_n16.sv
// Bench joining transmit and receive ends through the link interface.
// Assumes the register map of the transmit end and one 40 MHz clock.
module test_jesd204b_link_param_config_n16;
    timeunit 1ns;
    timeprecision 100ps;
    import link_cfg_pkg::*;
    localparam logic [31:0] SH_B = 32'h0000_2421;
    localparam logic [31:0] SH_Q = 32'h0001_4114;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wrData = 32'h0000_0000;
    logic wrStb = 1'b0;
    logic rdStb = 1'b0;
    logic stall = 1'b0;
    logic [31:0] rdData;
    logic linkUp, cfgFault, loadPulse;
    logic [7:0] bandSet;
    link_cfg_t activeCfg;
    int n_fail = 0;
    int n_compared = 0;
    link_cfg_if link_cfg_if_inst ();
    link_cfg_tx link_cfg_tx_inst (.clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData),
        .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .link(link_cfg_if_inst));
    link_cfg_rx link_cfg_rx_inst (.clk(clk), .rst_n(rst_n), .link(link_cfg_if_inst),
        .stall(stall), .linkUp(linkUp), .cfgFault(cfgFault), .loadPulse(loadPulse),
        .bandSet(bandSet), .activeCfg(activeCfg));
    link_cfg_sva link_cfg_sva_inst (.clk(clk), .rst_n(rst_n),
        .cfgValid(link_cfg_if_inst.cfgValid), .cfgReady(link_cfg_if_inst.cfgReady),
        .cfgWord(link_cfg_if_inst.cfgWord), .loadPulse(loadPulse), .linkUp(linkUp),
        .bandSet(bandSet), .activeCfg(activeCfg));
    initial begin
        forever #12.5 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrStb <= 1'b1;
        @(posedge clk);
        wrStb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge clk);
        rdStb <= 1'b0;
        #1;
        d = rdData;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // Status mask keeps band only when the config is expected legal
    task automatic run_cfg(input logic [31:0] sh, input logic [31:0] wd, input logic [5:0] dc,
        input logic [23:0] rt, input logic [20:0] ck, input logic [31:0] cmd, input logic [15:0] ex);
        logic [31:0] s;
        wr(REG_SHAPE, sh);
        wr(REG_WORD, wd);
        wr(REG_DECIM, 32'(dc));
        wr(REG_RATE, 32'(rt));
        wr(REG_CLOCK, 32'(ck));
        wr(REG_CMD, cmd);
        rd(REG_STATUS, s);
        chk("status", 32'(ex), s & (ex[7] ? 32'h0000_FFFF : 32'h0000_00FF));
    endtask
    task automatic wait_load();
        for (int i = 0; i < 20; i++) begin
            @(posedge clk);
            #1;
            if (loadPulse === 1'b1) break;
        end
        chk("load pulse", 32'h0000_0001, 32'(loadPulse));
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_regs();
        logic [31:0] s;
        wr(REG_SHAPE, 32'hFFFF_FFFF);
        wr(8'h20, 32'h0000_0000);
        rd(REG_SHAPE, s);
        chk("shape readback", 32'h0001_FFFF, s);
        rd(8'h20, s);
        chk("unmapped read", 32'h0000_0000, s);
        rd(REG_CMD, s);
        chk("command read", 32'h0000_0000, s);
    endtask
    task automatic test_table();
        run_cfg(SH_B, 32'h470, 6'h04, 24'h26_25A0, 21'h3_D090, 3, 16'h5080);
        run_cfg(SH_B, 32'h470, 6'h04, 24'h4C_4B40, 21'h7_A120, 3, 16'h1080);
        run_cfg(SH_B, 32'h470, 6'h02, 24'h98_9680, 21'h7_A120, 3, 16'h0080);
        run_cfg(32'h3081, 32'h210, 6'h04, 24'hE4_E1C0, 21'h5_B8D8, 3, 16'h3080);
        run_cfg(SH_Q, 32'hA10, 6'h01, 24'h19_BFCC, 21'h5_265C, 3, 16'h5080);
        run_cfg(SH_Q, 32'hA10, 6'h01, 24'h16_E360, 21'h4_93E0, 3, 16'h0040);
        run_cfg(SH_Q, 32'hA10, 6'h11, 24'h01_86A0, 21'h5_3020, 3, 16'h0052);
        run_cfg(SH_Q, 32'h810, 6'h01, 24'h19_BFCC, 21'h5_265C, 3, 16'h0008);
        run_cfg(SH_B, 32'h370, 6'h04, 24'h26_25A0, 21'h3_D090, 3, 16'h0008);
        run_cfg(SH_B, 32'h270, 6'h04, 24'h26_25A0, 21'h3_D090, 3, 16'h0008);
        run_cfg(SH_B, 32'h470, 6'h06, 24'h1E_8480, 21'h4_93E0, 3, 16'h0002);
        run_cfg(32'h1_2421, 32'h470, 6'h04, 24'h26_25A0, 21'h3_D090, 3, 16'h0004);
        run_cfg(SH_B, 32'h467, 6'h04, 24'h26_25A0, 21'h3_D090, 3, 16'h0004);
    endtask
    // Receiver stalls so both entries fill and a third commit bounces
    task automatic test_link();
        logic [31:0] s;
        wr(REG_CMD, 32'h0000_0004);
        stall <= 1'b1;
        run_cfg(SH_B, 32'h470, 6'h04, 24'h26_25A0, 21'h3_D090, 1, 16'h5080);
        run_cfg(SH_B, 32'h470, 6'h04, 24'h4C_4B40, 21'h7_A120, 1, 16'h1080);
        wr(REG_CMD, 32'h0000_0001);
        rd(REG_STATUS, s);
        chk("reject and full", 32'h0006_0000, s & 32'h0006_0000);
        chk("link idle", 32'h0000_0000, 32'(linkUp));
        stall <= 1'b0;
        wait_load();
        chk("first rate", 32'h0026_25A0, 32'(activeCfg.laneKbps));
        chk("first band", 32'h0000_0050, 32'(bandSet));
        chk("shape", 32'h0000_9108, 32'({activeCfg.lanes, activeCfg.convs, activeCfg.octets,
            activeCfg.frames}));
        wait_load();
        chk("second rate", 32'h004C_4B40, 32'(activeCfg.laneKbps));
        chk("second band", 32'h0000_0010, 32'(bandSet));
        chk("link up", 32'h0000_0001, 32'(linkUp));
        chk("link fault", 32'h0000_0000, 32'(cfgFault));
        wr(REG_CMD, 32'h0000_0004);
        rd(REG_STATUS, s);
        chk("reject cleared", 32'h0000_0000, s & 32'h0002_0000);
    endtask
    task automatic wrap_up();
        if (n_fail == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        test_regs();
        test_table();
        test_link();
        wrap_up();
    end
    // Tests need well under two thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        wrap_up();
    end
endmodule // test_jesd204b_link_param_config_n16
